//--- logic/ptr_threshold_regs.sv
// Functional notes
// - hold 16-bit thresholds, compare per channel
// - bytes mapped at 0x13, 0x14, 0x15, 0x16
// - half-written threshold may be compared mixed
// - old revisions: 8-bit compressed at 0x13/0x15
// - parameter mailbox at 0x17, read-write
// - all bytes reset to zero
// - channel two low byte at 0x13
// - command write at 0x18 consumes mailbox
module ptr_threshold_regs
  import ptr_pkg::*;
#(
  parameter int TH_W = 16
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire ptr_req_s    req,
  input  wire logic        legacy_mode,
  input  wire ptr_meas_s   meas2,
  input  wire ptr_meas_s   meas3,
  output logic [7:0]       rdata,
  output logic             rvalid,
  output logic [TH_W-1:0]  prox2_threshold,
  output logic [TH_W-1:0]  prox3_threshold,
  output logic             prox2_over,
  output logic             prox3_over,
  output logic             cmd_strobe,
  output logic [7:0]       cmd_code,
  output logic [7:0]       cmd_param
);
  if (TH_W != 2 * BYTE_W) begin : g_bad_width
    $error("threshold width must be two bytes");
  end

  logic [NUM_BYTES-1:0]        we;
  logic [NUM_BYTES*BYTE_W-1:0] bank;
  logic [7:0] p2_lo, p2_hi, p3_lo, p3_hi, param;

  assign p2_lo = bank[0*BYTE_W +: BYTE_W];
  assign p2_hi = bank[1*BYTE_W +: BYTE_W];
  assign p3_lo = bank[2*BYTE_W +: BYTE_W];
  assign p3_hi = bank[3*BYTE_W +: BYTE_W];
  assign param = bank[4*BYTE_W +: BYTE_W];

  // byte decode; legacy single bytes land in low-byte slots
  always_comb begin
    we = '0;
    if (req.wr) begin
      if (legacy_mode) begin
        we[0] = (req.addr == OFS_LEGACY_P2);
        we[2] = (req.addr == OFS_LEGACY_P3);
      end else begin
        we[0] = (req.addr == OFS_P2_LO);
        we[1] = (req.addr == OFS_P2_HI);
        we[2] = (req.addr == OFS_P3_LO);
        we[3] = (req.addr == OFS_P3_HI);
      end
      we[4] = (req.addr == OFS_PARAM);
    end
  end

  ptr_byte_bank #(
    .N (NUM_BYTES)
  ) u_bank (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .we      (we),
    .wdata   (req.wdata),
    .q       (bank)
  );

  // compressed legacy value: top nibble exponent, low nibble mantissa
  function automatic logic [TH_W-1:0] expand(input logic [7:0] c);
    logic [TH_W-1:0] m;
    m = {{(TH_W-5){1'b0}}, 1'b1, c[3:0]};
    if (c == 8'h00) begin
      expand = '0;
    end else if (c[7:4] >= 4'h4) begin
      expand = m << (c[7:4] - 4'h4);
    end else begin
      expand = m >> (4'h4 - c[7:4]);
    end
  endfunction : expand

  logic [TH_W-1:0] th2, th3;
  logic [7:0]      next_rdata;
  logic            next_rvalid, next_over2, next_over3, next_cmd;

  always_comb begin
    // bytes apply as they arrive, so a half update is live
    th2 = legacy_mode ? expand(p2_lo) : {p2_hi, p2_lo};
    th3 = legacy_mode ? expand(p3_lo) : {p3_hi, p3_lo};
    next_over2 = prox2_over;
    next_over3 = prox3_over;
    if (meas2.valid) next_over2 = (meas2.value > th2);
    if (meas3.valid) next_over3 = (meas3.value > th3);
    next_rvalid = req.rd;
    next_rdata  = 8'h00;
    if (req.rd) begin
      case (req.addr)
        OFS_P2_LO: next_rdata = p2_lo;
        OFS_P2_HI: next_rdata = legacy_mode ? 8'h00 : p2_hi;
        OFS_P3_LO: next_rdata = p3_lo;
        OFS_P3_HI: next_rdata = legacy_mode ? 8'h00 : p3_hi;
        OFS_PARAM: next_rdata = param;
        default:   next_rdata = 8'h00;
      endcase
    end
    next_cmd = req.wr && (req.addr == OFS_CMD);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata           <= RST_BYTE;
      rvalid          <= 1'b0;
      prox2_threshold <= '0;
      prox3_threshold <= '0;
      prox2_over      <= 1'b0;
      prox3_over      <= 1'b0;
      cmd_strobe      <= 1'b0;
      cmd_code        <= RST_BYTE;
      cmd_param       <= RST_BYTE;
    end else if (ce) begin
      rdata           <= next_rdata;
      rvalid          <= next_rvalid;
      prox2_threshold <= th2;
      prox3_threshold <= th3;
      prox2_over      <= next_over2;
      prox3_over      <= next_over3;
      cmd_strobe      <= next_cmd;
      if (next_cmd) begin
        cmd_code  <= req.wdata;
        cmd_param <= param;
      end
    end
  end

  mbox_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    ce && req.wr && req.addr == OFS_PARAM ##1 ce && !req.wr
    ##1 ce && req.rd && req.addr == OFS_PARAM
    |=> rdata == $past(req.wdata, 3))
    else $error("mailbox did not hold written byte");

  th_pair_a: assert property (@(posedge clk_sys) disable iff (rst)
    ce && !legacy_mode && req.wr && req.addr == OFS_P3_HI ##1 ce && !legacy_mode
    |=> prox3_threshold[15:8] == $past(req.wdata, 2))
    else $error("channel three high byte not applied");

  lo_pair_a: assert property (@(posedge clk_sys) disable iff (rst)
    ce && !legacy_mode && req.wr && req.addr == OFS_P2_LO ##1 ce && !legacy_mode
    |=> prox2_threshold[7:0] == $past(req.wdata, 2))
    else $error("channel two low byte not applied");

  half_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    ce && !legacy_mode && req.wr && req.addr == OFS_P2_HI ##1 ce && !legacy_mode
    && !req.wr |=> prox2_threshold == {$past(req.wdata, 2), p2_lo})
    else $error("half written threshold not live");

  cmd_consume_a: assert property (@(posedge clk_sys) disable iff (rst)
    ce && req.wr && req.addr == OFS_CMD |=> cmd_strobe && cmd_param == $past(param))
    else $error("command did not capture mailbox");

  cmd_pulse_a: assert property (@(posedge clk_sys) disable iff (rst)
    ce && !(req.wr && req.addr == OFS_CMD) |=> !cmd_strobe)
    else $error("command strobe without write");

  compare_a: assert property (@(posedge clk_sys) disable iff (rst)
    ce && meas3.valid && !req.wr |=> prox3_over == ($past(meas3.value) > $past(th3)))
    else $error("channel three compare wrong");

  reset_zero_a: assert property (@(posedge clk_sys)
    rst |=> bank == '0 && rdata == 8'h00 && !rvalid && !cmd_strobe)
    else $error("byte not zero after reset");

  legacy_hi_a: assert property (@(posedge clk_sys) disable iff (rst)
    ce && legacy_mode && req.rd && req.addr == OFS_P2_HI |=> rdata == 8'h00)
    else $error("legacy high byte not zero");

  rvalid_pulse_a: assert property (@(posedge clk_sys) disable iff (rst)
    ce |=> rvalid == $past(req.rd))
    else $error("read valid does not follow read strobe");

  rdata_idle_a: assert property (@(posedge clk_sys) disable iff (rst)
    ce && !req.rd |=> rdata == 8'h00)
    else $error("read data not zero outside a read");

  cmd_unread_a: assert property (@(posedge clk_sys) disable iff (rst)
    ce && req.rd && req.addr == OFS_CMD |=> rdata == 8'h00)
    else $error("command byte readable");

  cmd_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    ce && !(req.wr && req.addr == OFS_CMD) |=> $stable(cmd_code) && $stable(cmd_param))
    else $error("command outputs changed without write");

  legacy_skip_a: assert property (@(posedge clk_sys) disable iff (rst)
    ce && legacy_mode && req.wr && req.addr == OFS_P2_HI |=> $stable(p2_hi))
    else $error("legacy mode stored a high byte");

  // smallest nonzero code still expands to at least one
  legacy_nonzero_a: assert property (@(posedge clk_sys) disable iff (rst)
    ce && legacy_mode && req.wr && req.addr == OFS_LEGACY_P2 && req.wdata != 8'h00
    ##1 ce && legacy_mode |=> prox2_threshold != '0)
    else $error("legacy code expanded to zero");

  over_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    ce && !meas2.valid |=> $stable(prox2_over))
    else $error("channel two flag moved without measurement");

  // ce low must hold every register, read side included
  freeze_a: assert property (@(posedge clk_sys) disable iff (rst)
    !ce |=> $stable(bank) && $stable(prox3_threshold) && $stable(rvalid))
    else $error("state moved with clock enable low");

  // main scenarios
  cov_cmd_c:    cover property (@(posedge clk_sys) cmd_strobe);
  cov_over2_c:  cover property (@(posedge clk_sys) prox2_over);
  cov_legacy_c: cover property (@(posedge clk_sys) legacy_mode && prox3_over);
  cov_freeze_c: cover property (@(posedge clk_sys) !ce && req.wr);
  cov_read_c:   cover property (@(posedge clk_sys) rvalid && rdata != 8'h00);
endmodule : ptr_threshold_regs

//--- logic/ptr_pkg.sv
package ptr_pkg;
  localparam logic [7:0] OFS_P2_LO      = 8'h13;
  localparam logic [7:0] OFS_P2_HI      = 8'h14;
  localparam logic [7:0] OFS_P3_LO      = 8'h15;
  localparam logic [7:0] OFS_P3_HI      = 8'h16;
  localparam logic [7:0] OFS_PARAM      = 8'h17;
  localparam logic [7:0] OFS_CMD        = 8'h18;
  localparam logic [7:0] OFS_LEGACY_P2  = 8'h13;
  localparam logic [7:0] OFS_LEGACY_P3  = 8'h15;
  localparam logic [7:0] RST_BYTE       = 8'h00;
  localparam int         BYTE_W         = 8;
  localparam int         NUM_BYTES      = 5;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ptr_req_s;

  typedef struct packed {
    logic        valid;
    logic [15:0] value;
  } ptr_meas_s;
endpackage : ptr_pkg

//--- logic/ptr_byte_bank.sv
module ptr_byte_bank
  import ptr_pkg::*;
#(
  parameter int N = NUM_BYTES
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  input  wire logic                 ce,
  input  wire logic [N-1:0]         we,
  input  wire logic [BYTE_W-1:0]    wdata,
  output logic      [N*BYTE_W-1:0]  q
);
  if (N < 1) begin : g_bad_n
    $error("ptr_byte_bank needs at least one byte");
  end

  logic [N*BYTE_W-1:0] next_q;

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_byte
      always_comb begin
        next_q[i*BYTE_W +: BYTE_W] = q[i*BYTE_W +: BYTE_W];
        if (we[i]) begin
          next_q[i*BYTE_W +: BYTE_W] = wdata;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= {N{RST_BYTE}};
    end else if (ce) begin
      q <= next_q;
    end
  end
endmodule : ptr_byte_bank

//--- sim/ptr_host_model.sv
module ptr_host_model
  import ptr_pkg::*;
#(
  parameter logic [7:0] PAUSE_CMD = 8'h0b
) (
  input  wire logic       clk_sys,
  input  wire logic [7:0] rdata,
  input  wire logic       rvalid,
  output ptr_req_s        req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req = '0;
  // released address and data show the inverse, never the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge clk_sys);
    req <= '{1'b0, 1'b0, ~a, ~d};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk_sys);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk_sys);
    req <= '{1'b0, 1'b0, ~a, 8'hff};
    @(posedge clk_sys);
    d = rdata;
    v = rvalid;
  endtask : rd
  // pause first, then both bytes; bench keeps measurements idle meanwhile
  task automatic upd(input logic [7:0] a, input logic [15:0] t);
    wr(OFS_CMD, PAUSE_CMD);
    wr(a, t[7:0]);
    wr(a + 8'h01, t[15:8]);
  endtask : upd
endmodule : ptr_host_model

//--- sim/prox_threshold_param_regs_tb_top.sv
module prox_threshold_param_regs_tb_top
  import ptr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, rst, ce, legacy_mode, rvalid, p2o, p3o, cmd_strobe, v;
  ptr_req_s    req;
  ptr_meas_s   meas2, meas3;
  logic [7:0]  rdata, cmd_code, cmd_param, d;
  logic [15:0] p2t, p3t;
  int          fails, checks_done, cycles;
  ptr_threshold_regs i_ptr_threshold_regs (.clk_sys(clk_sys), .rst(rst), .ce(ce),
    .req(req), .legacy_mode(legacy_mode), .meas2(meas2), .meas3(meas3), .rdata(rdata),
    .rvalid(rvalid), .prox2_threshold(p2t), .prox3_threshold(p3t), .prox2_over(p2o),
    .prox3_over(p3o), .cmd_strobe(cmd_strobe), .cmd_code(cmd_code), .cmd_param(cmd_param));
  ptr_host_model i_ptr_host_model (.clk_sys(clk_sys), .rdata(rdata), .rvalid(rvalid),
    .req(req));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    i_ptr_host_model.rd(a, d, v);
    chk({15'h0000, v}, 16'h0001);
    chk({8'h00, d}, {8'h00, exp});
  endtask : rdc
  task automatic t_reset();
    for (int i = 0; i < 5; i++) rdc(OFS_P2_LO + 8'(i), RST_BYTE);
    chk(p2t | p3t, 16'h0000);
    $display("test reset done");
  endtask : t_reset
  task automatic t_map();
    i_ptr_host_model.upd(OFS_P2_LO, 16'ha511);
    i_ptr_host_model.upd(OFS_P3_LO, 16'h3c7e);
    i_ptr_host_model.wr(OFS_PARAM, 8'h69);
    repeat (2) @(posedge clk_sys);
    chk(p2t, 16'ha511);
    chk(p3t, 16'h3c7e);
    rdc(OFS_P2_LO, 8'h11);
    rdc(OFS_P2_HI, 8'ha5);
    rdc(OFS_P3_LO, 8'h7e);
    rdc(OFS_P3_HI, 8'h3c);
    rdc(OFS_PARAM, 8'h69);
    rdc(8'h30, 8'h00);
    $display("test map done");
  endtask : t_map
  task automatic t_half();
    i_ptr_host_model.wr(OFS_P3_LO, 8'h01);
    repeat (2) @(posedge clk_sys);
    chk(p3t, 16'h3c01);
    $display("test half done");
  endtask : t_half
  task automatic t_cmp(input logic [15:0] m, input logic exp);
    @(posedge clk_sys);
    meas2 <= '{1'b1, m};
    meas3 <= '{1'b1, m - 16'h6893};
    @(posedge clk_sys);
    meas2 <= '0;
    meas3 <= '0;
    @(posedge clk_sys);
    chk({15'h0, p2o}, {15'h0, exp});
    chk({15'h0, p3o}, {15'h0, exp});
    $display("test compare done");
  endtask : t_cmp
  task automatic t_cmd();
    i_ptr_host_model.wr(OFS_PARAM, 8'h5a);
    i_ptr_host_model.wr(OFS_CMD, 8'hc3);
    @(posedge clk_sys);
    chk({7'h0, cmd_strobe, cmd_code}, 16'h01c3);
    chk({8'h0, cmd_param}, 16'h005a);
    @(posedge clk_sys);
    chk({15'h0, cmd_strobe}, 16'h0000);
    rdc(OFS_CMD, 8'h00);
    i_ptr_host_model.wr(OFS_PARAM, 8'ha6);
    rdc(OFS_PARAM, 8'ha6);
    $display("test command done");
  endtask : t_cmd
  task automatic t_freeze();
    ce <= 1'b0;
    i_ptr_host_model.wr(OFS_PARAM, 8'h3f);
    ce <= 1'b1;
    rdc(OFS_PARAM, 8'ha6);
    $display("test freeze done");
  endtask : t_freeze
  task automatic t_legacy();
    legacy_mode <= 1'b1;
    i_ptr_host_model.wr(OFS_LEGACY_P2, 8'h44);
    i_ptr_host_model.wr(OFS_P2_HI, 8'h99);
    i_ptr_host_model.wr(OFS_LEGACY_P3, 8'h00);
    repeat (2) @(posedge clk_sys);
    chk(p2t, 16'h0014);
    chk(p3t, 16'h0000);
    rdc(OFS_P2_HI, 8'h00);
    t_cmp(16'ha512, 1'b1);
    $display("test legacy done");
  endtask : t_legacy
  task automatic end_of_test();
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      end_of_test();
    end
  end
  initial begin
    rst = 1'b1;
    legacy_mode = 1'b0;
    ce = 1'b1;
    meas2 = '0;
    meas3 = '0;
    cycles = 0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_map();
    t_cmp(16'ha512, 1'b1);
    t_cmp(16'ha511, 1'b0);
    t_half();
    t_cmd();
    t_freeze();
    t_legacy();
    end_of_test();
  end
endmodule : prox_threshold_param_regs_tb_top
